// file: core/ccb_config_bank.v
`timescale 1ns/1ns
`include "ccb_consts.vh"
// Summary of operation
// - Block write: index, count, data, all acknowledged.
// - Block read: count first, then data bytes.
// - General bit 7 flags programmed configuration memory.
// - General bits 6:5 pick serial target address.
// - General bit 4 enables first PLL spread.
// - Third PLL bypass bits replace reference divider.
// - Six-bit reference dividers, ratio 1 to 64.
// - Third PLL feedback divider, eleven bits, 480.
// - First PLL feedback divider, eleven bits, 600.
// - Third PLL filter bits add series resistors.
// - First PLL filter bits, reset pattern 10110.
// - Byte 6 bit 7 picks divider 3 source.
// - Charge pump current from weights and divisors.
// - Reference current select bits per PLL.
// - Doubler, second channel, extra pole controls.
// - Output divider 5 is prescale times factor.
// - First PLL bypass bits replace reference divider.
// - First PLL spread dividers, reset to zero.
// - Byte 15 holds output dividers 1 and 2.
module ccb_config_bank (
  // Clock, reset, enable
  input  wire        core_clk,
  input  wire        srst,
  input  wire        ce,
  // Serial pins
  input  wire        sclIn,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOe,
  // General control
  output wire        nvmProgrammed,
  output wire [1:0]  targetAddrSel,
  output wire        pllASpreadEnable,
  output wire        pllCRefSourceSelect,
  output wire        writeLocked,
  output wire [7:0]  variantCode,
  // Third PLL
  output wire        pllCRefBypassDiv1,
  output wire        pllCRefBypassDiv2,
  output wire [5:0]  pllCRefDivider,
  output reg  [6:0]  pllCRefRatio,
  output wire [10:0] pllCFbDivider,
  output wire [4:0]  pllCFilter,
  output wire        outDivCSourceSelect,
  output wire        pllCRefCurrentSelect,
  output reg  [4:0]  pllCPumpMult,
  output reg  [4:0]  pllCPumpDivisor,
  // First PLL
  output wire        pllARefDoubler,
  output wire        pllARefCurrentSelect,
  output wire        pllASecondChannelEnable,
  output wire        pllAExtraPoleEnable,
  output wire        pllARefBypassDiv1,
  output wire        pllARefBypassDiv2,
  output wire [5:0]  pllARefDivider,
  output reg  [6:0]  pllARefRatio,
  output wire [10:0] pllAFbDivider,
  output wire [4:0]  pllAFilter,
  output reg  [6:0]  pllAPumpMult,
  output reg  [4:0]  pllAPumpDivisor,
  output wire [7:0]  pllASpreadRefDivider,
  output wire [15:0] pllASpreadFbDivider,
  // Output dividers
  output reg  [6:0]  outDivARatio,
  output reg  [6:0]  outDivBRatio,
  output reg  [6:0]  outDivERatio
);
  localparam [2:0] ST_IDLE      = 3'h0;
  localparam [2:0] ST_ADDR      = 3'h1;
  localparam [2:0] ST_ADDR_ACK  = 3'h2;
  localparam [2:0] ST_WRITE     = 3'h3;
  localparam [2:0] ST_WRITE_ACK = 3'h4;
  localparam [2:0] ST_READ      = 3'h5;
  localparam [2:0] ST_READ_ACK  = 3'h6;
  reg  [7:0] bankMem_r [0:15];
  reg  [1:0] pinMeta_r;
  reg  [1:0] pinSync_r;
  reg  [1:0] pinPrev_r;
  reg  [2:0] state_r;
  reg  [3:0] bitCnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] index_r;
  reg  [7:0] remain_r;
  reg  [1:0] byteNum_r;
  reg        readMode_r;
  reg        oe_r;
  integer    i;
  wire [1:0] pinRaw;
  wire       sclS;
  wire       sdaS;
  wire       sclRise;
  wire       sclFall;
  wire       startCond;
  wire       stopCond;
  wire [6:0] ownAddr;
  wire       inBank;
  wire [3:0] idx;
  wire       wrAllowed;
  wire [7:0] wrMask;
  wire [7:0] rdByte;
  wire [7:0] countByte;
  wire [11:0] divCodes;
  wire [20:0] divRatios;
  function [7:0] resetByte;
    input [3:0] off;
    begin
      case (off)
        `CCB_OFF_GENERAL:     resetByte = `CCB_RST_GENERAL;
        `CCB_OFF_C_REF_DIV:   resetByte = `CCB_RST_C_REF_DIV;
        `CCB_OFF_C_FB_LOW:    resetByte = `CCB_RST_C_FB_LOW;
        `CCB_OFF_C_FILT_FB:   resetByte = `CCB_RST_C_FILT_FB;
        `CCB_OFF_C_PUMP:      resetByte = `CCB_RST_C_PUMP;
        `CCB_OFF_A_CTRL_DIVE: resetByte = `CCB_RST_A_CTRL_DIVE;
        `CCB_OFF_A_REF_DIV:   resetByte = `CCB_RST_A_REF_DIV;
        `CCB_OFF_A_FB_LOW:    resetByte = `CCB_RST_A_FB_LOW;
        `CCB_OFF_A_FILT_FB:   resetByte = `CCB_RST_A_FILT_FB;
        `CCB_OFF_A_PUMP:      resetByte = `CCB_RST_A_PUMP;
        `CCB_OFF_OUT_DIV_AB:  resetByte = `CCB_RST_OUT_DIV_AB;
        default:              resetByte = `CCB_RST_OTHER;
      endcase
    end
  endfunction
  // Both pins cross into the core clock through two flip-flops.
  assign pinRaw = {sclIn, sdaIn};
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gSync
      always @(posedge core_clk) begin
        if (srst) begin
          pinMeta_r[g] <= 1'b1;
          pinSync_r[g] <= 1'b1;
          pinPrev_r[g] <= 1'b1;
        end else if (ce) begin
          pinMeta_r[g] <= pinRaw[g];
          pinSync_r[g] <= pinMeta_r[g];
          pinPrev_r[g] <= pinSync_r[g];
        end
      end
    end
  endgenerate
  assign sclS      = pinSync_r[1];
  assign sdaS      = pinSync_r[0];
  assign sclRise   = sclS & ~pinPrev_r[1];
  assign sclFall   = ~sclS & pinPrev_r[1];
  assign startCond = sclS & pinPrev_r[1] & pinPrev_r[0] & ~sdaS;
  assign stopCond  = sclS & pinPrev_r[1] & ~pinPrev_r[0] & sdaS;
  // The select code moves the target address in steps of one.
  assign ownAddr = `CCB_TARGET_BASE |
                   {5'h00, bankMem_r[`CCB_OFF_GENERAL][6:5]};
  assign inBank    = index_r < `CCB_BANK_BYTES;
  assign idx       = index_r[3:0];
  // The general byte stays writable so the lock can be released.
  assign wrAllowed = inBank & ((idx == `CCB_OFF_GENERAL) |
                     ~bankMem_r[`CCB_OFF_GENERAL][`CCB_GEN_LOCK_BIT]);
  assign wrMask    = (idx == `CCB_OFF_GENERAL) ? `CCB_WMASK_GENERAL :
                     (idx == `CCB_OFF_CRYSTAL) ? `CCB_WMASK_CRYSTAL :
                     `CCB_WMASK_OTHER;
  assign rdByte    = inBank ? bankMem_r[idx] : 8'h00;
  assign countByte = inBank ? (`CCB_BANK_BYTES - index_r) : 8'h00;
  // Serial target: address, index, count, data, with acknowledges.
  always @(posedge core_clk) begin
    if (srst) begin
      state_r    <= ST_IDLE;
      bitCnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      index_r    <= 8'h00;
      remain_r   <= 8'h00;
      byteNum_r  <= 2'h0;
      readMode_r <= 1'b0;
      oe_r       <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        bankMem_r[i] <= resetByte(i[3:0]);
      end
    end else if (ce) begin
      if (startCond) begin
        state_r  <= ST_ADDR;
        bitCnt_r <= 4'h0;
        oe_r     <= 1'b0;
      end else if (stopCond) begin
        state_r <= ST_IDLE;
        oe_r    <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_WRITE: begin
            if (sclRise && bitCnt_r != 4'h8) begin
              shift_r  <= {shift_r[6:0], sdaS};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              bitCnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == ownAddr) begin
                  oe_r       <= 1'b1;
                  readMode_r <= shift_r[0];
                  state_r    <= ST_ADDR_ACK;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                oe_r    <= 1'b1;
                state_r <= ST_WRITE_ACK;
                if (byteNum_r != 2'h2) begin
                  byteNum_r <= byteNum_r + 2'h1;
                end
                case (byteNum_r)
                  2'h0: index_r <= shift_r;
                  2'h1: remain_r <= shift_r;
                  default: begin
                    if (remain_r != 8'h00) begin
                      if (wrAllowed) begin
                        bankMem_r[idx] <= (bankMem_r[idx] & ~wrMask) |
                                          (shift_r & wrMask);
                      end
                      index_r  <= index_r + 8'h01;
                      remain_r <= remain_r - 8'h01;
                    end
                  end
                endcase
              end
            end
          end
          ST_ADDR_ACK: begin
            if (sclFall) begin
              if (readMode_r) begin
                oe_r     <= ~countByte[7];
                shift_r  <= {countByte[6:0], 1'b0};
                bitCnt_r <= 4'h1;
                state_r  <= ST_READ;
              end else begin
                oe_r      <= 1'b0;
                byteNum_r <= 2'h0;
                state_r   <= ST_WRITE;
              end
            end
          end
          ST_WRITE_ACK: begin
            if (sclFall) begin
              oe_r    <= 1'b0;
              state_r <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (sclFall) begin
              if (bitCnt_r == 4'h8) begin
                oe_r    <= 1'b0;
                state_r <= ST_READ_ACK;
              end else begin
                oe_r     <= ~shift_r[7];
                shift_r  <= {shift_r[6:0], 1'b0};
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          ST_READ_ACK: begin
            if (sclRise && sdaS) begin
              state_r <= ST_IDLE;
            end else if (sclFall) begin
              oe_r     <= ~rdByte[7];
              shift_r  <= {rdByte[6:0], 1'b0};
              bitCnt_r <= 4'h1;
              index_r  <= index_r + 8'h01;
              state_r  <= ST_READ;
            end
          end
          default: begin
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end
  // Open-drain data pin: only ever pulls low.
  assign sdaOut = 1'b0;
  assign sdaOe  = oe_r;
  // Fields straight from the register bank.
  assign nvmProgrammed = bankMem_r[`CCB_OFF_GENERAL][`CCB_GEN_NVM_BIT];
  assign targetAddrSel        =
    bankMem_r[`CCB_OFF_GENERAL][`CCB_GEN_ADDR_HI:`CCB_GEN_ADDR_LO];
  assign pllASpreadEnable     =
    bankMem_r[`CCB_OFF_GENERAL][`CCB_GEN_SPREAD_BIT];
  assign pllCRefSourceSelect  =
    bankMem_r[`CCB_OFF_GENERAL][`CCB_GEN_REFSEL_BIT];
  assign writeLocked = bankMem_r[`CCB_OFF_GENERAL][`CCB_GEN_LOCK_BIT];
  assign variantCode          = bankMem_r[`CCB_OFF_VARIANT];
  assign pllCRefBypassDiv1    = bankMem_r[`CCB_OFF_C_REF_DIV][7];
  assign pllCRefBypassDiv2    = bankMem_r[`CCB_OFF_C_REF_DIV][6];
  assign pllCRefDivider       = bankMem_r[`CCB_OFF_C_REF_DIV][5:0];
  assign pllCFbDivider        = {bankMem_r[`CCB_OFF_C_FILT_FB][2:0],
                                 bankMem_r[`CCB_OFF_C_FB_LOW]};
  assign pllCFilter           = bankMem_r[`CCB_OFF_C_FILT_FB][7:3];
  assign outDivCSourceSelect  = bankMem_r[`CCB_OFF_C_PUMP][7];
  assign pllCRefCurrentSelect = bankMem_r[`CCB_OFF_C_PUMP][0];
  assign pllARefDoubler          = bankMem_r[`CCB_OFF_A_CTRL_DIVE][7];
  assign pllARefCurrentSelect    = bankMem_r[`CCB_OFF_A_CTRL_DIVE][6];
  assign pllASecondChannelEnable = bankMem_r[`CCB_OFF_A_CTRL_DIVE][5];
  assign pllAExtraPoleEnable     = bankMem_r[`CCB_OFF_A_CTRL_DIVE][4];
  assign pllARefBypassDiv1    = bankMem_r[`CCB_OFF_A_REF_DIV][7];
  assign pllARefBypassDiv2    = bankMem_r[`CCB_OFF_A_REF_DIV][6];
  assign pllARefDivider       = bankMem_r[`CCB_OFF_A_REF_DIV][5:0];
  assign pllAFbDivider        = {bankMem_r[`CCB_OFF_A_FILT_FB][2:0],
                                 bankMem_r[`CCB_OFF_A_FB_LOW]};
  assign pllAFilter           = bankMem_r[`CCB_OFF_A_FILT_FB][7:3];
  assign pllASpreadRefDivider = bankMem_r[`CCB_OFF_A_SS_REF];
  assign pllASpreadFbDivider  = {bankMem_r[`CCB_OFF_A_SS_FB_HIGH],
                                 bankMem_r[`CCB_OFF_A_SS_FB_LOW]};
  // Output divider codes: divider 1, divider 2, divider 5.
  assign divCodes = {bankMem_r[`CCB_OFF_OUT_DIV_AB][7:4],
                     bankMem_r[`CCB_OFF_OUT_DIV_AB][3:0],
                     bankMem_r[`CCB_OFF_A_CTRL_DIVE][3:0]};
  generate
    for (g = 0; g < 3; g = g + 1) begin : gDiv
      ccb_div_decode uDec (
        .code  (divCodes[4*g+3:4*g]),
        .ratio (divRatios[7*g+6:7*g])
      );
    end
  endgenerate
  // Derived settings are registered so they move one cycle after a write.
  always @(posedge core_clk) begin
    if (srst) begin
      pllCRefRatio    <= 7'h00;
      pllARefRatio    <= 7'h00;
      pllCPumpMult    <= 5'h00;
      pllCPumpDivisor <= 5'h00;
      pllAPumpMult    <= 7'h00;
      pllAPumpDivisor <= 5'h00;
      outDivARatio    <= 7'h00;
      outDivBRatio    <= 7'h00;
      outDivERatio    <= 7'h00;
    end else if (ce) begin
      if (pllCRefBypassDiv1) begin
        pllCRefRatio <= 7'h01;
      end else if (pllCRefBypassDiv2) begin
        pllCRefRatio <= 7'h02;
      end else if (pllCRefDivider == 6'h00) begin
        pllCRefRatio <= `CCB_REF_DIV_TOP;
      end else begin
        pllCRefRatio <= {1'b0, pllCRefDivider};
      end
      if (pllARefBypassDiv1) begin
        pllARefRatio <= 7'h01;
      end else if (pllARefBypassDiv2) begin
        pllARefRatio <= 7'h02;
      end else if (pllARefDivider == 6'h00) begin
        pllARefRatio <= `CCB_REF_DIV_TOP;
      end else begin
        pllARefRatio <= {1'b0, pllARefDivider};
      end
      // Weight bits sit in binary order, so the weighted sum is the field.
      pllCPumpMult <= {1'b0, bankMem_r[`CCB_OFF_C_PUMP][6:3]}
                      << pllCRefCurrentSelect;
      pllCPumpDivisor <= (bankMem_r[`CCB_OFF_C_PUMP][2] ? 5'h18 : 5'h00) +
                         (bankMem_r[`CCB_OFF_C_PUMP][1] ? 5'h03 : 5'h00);
      pllAPumpMult <= {1'b0, bankMem_r[`CCB_OFF_A_PUMP][7:2]}
                      << pllARefCurrentSelect;
      pllAPumpDivisor <= (bankMem_r[`CCB_OFF_A_PUMP][1] ? 5'h18 : 5'h00) +
                         (bankMem_r[`CCB_OFF_A_PUMP][0] ? 5'h03 : 5'h00);
      outDivARatio <= divRatios[20:14];
      outDivBRatio <= divRatios[13:7];
      outDivERatio <= divRatios[6:0];
    end
  end
endmodule // ccb_config_bank

// file: core/ccb_consts.vh
`ifndef CCB_CONSTS_VH
`define CCB_CONSTS_VH

// Register offsets within the bank.
`define CCB_OFF_GENERAL      4'h0
`define CCB_OFF_VARIANT      4'h1
`define CCB_OFF_CRYSTAL      4'h2
`define CCB_OFF_C_REF_DIV    4'h3
`define CCB_OFF_C_FB_LOW     4'h4
`define CCB_OFF_C_FILT_FB    4'h5
`define CCB_OFF_C_PUMP       4'h6
`define CCB_OFF_A_CTRL_DIVE  4'h7
`define CCB_OFF_A_REF_DIV    4'h8
`define CCB_OFF_A_FB_LOW     4'h9
`define CCB_OFF_A_FILT_FB    4'hA
`define CCB_OFF_A_PUMP       4'hB
`define CCB_OFF_A_SS_REF     4'hC
`define CCB_OFF_A_SS_FB_LOW  4'hD
`define CCB_OFF_A_SS_FB_HIGH 4'hE
`define CCB_OFF_OUT_DIV_AB   4'hF
`define CCB_BANK_BYTES       8'h10

// Field positions in the general control byte.
`define CCB_GEN_NVM_BIT      7
`define CCB_GEN_ADDR_HI      6
`define CCB_GEN_ADDR_LO      5
`define CCB_GEN_SPREAD_BIT   4
`define CCB_GEN_REFSEL_BIT   2
`define CCB_GEN_LOCK_BIT     0

// Reset values.
`define CCB_RST_GENERAL      8'h00
`define CCB_RST_C_REF_DIV    8'h1A
`define CCB_RST_C_FB_LOW     8'hE0
`define CCB_RST_C_FILT_FB    8'h11
`define CCB_RST_C_PUMP       8'h6C
`define CCB_RST_A_CTRL_DIVE  8'h23
`define CCB_RST_A_REF_DIV    8'h1A
`define CCB_RST_A_FB_LOW     8'h58
`define CCB_RST_A_FILT_FB    8'hB2
`define CCB_RST_A_PUMP       8'h06
`define CCB_RST_OUT_DIV_AB   8'h03
`define CCB_RST_OTHER        8'h00

// Writable bit masks; reserved bits hold zero.
`define CCB_WMASK_GENERAL    8'hF5
`define CCB_WMASK_CRYSTAL    8'h00
`define CCB_WMASK_OTHER      8'hFF

// Seven-bit serial target address for select code 00.
`define CCB_TARGET_BASE      7'h68
// Reference divider field value zero stands for the top ratio.
`define CCB_REF_DIV_TOP      7'h40

`endif

// file: core/ccb_div_decode.v
`timescale 1ns/1ns
module ccb_div_decode (
  // Divider code: prescale select in bits 3:2, factor select in bits 1:0
  input  wire [3:0] code,
  // Resulting ratio
  output reg  [6:0] ratio
);
  reg [6:0] factor;

  always @* begin
    case (code[1:0])
      2'h0:    factor = 7'h01;
      2'h1:    factor = 7'h03;
      2'h2:    factor = 7'h05;
      default: factor = 7'h0A;
    endcase
    ratio = factor << code[3:2];
  end
endmodule // ccb_div_decode

// file: verification/ccb_config_bank_props.sv
`timescale 1ns/1ns
module ccb_config_bank_props (
  // Clock, reset and enable
  input wire        core_clk,
  input wire        srst,
  input wire        ce,
  // Serial pins
  input wire        sclIn,
  input wire        sdaOut,
  input wire        sdaOe,
  // General control
  input wire        nvmProgrammed,
  input wire [1:0]  targetAddrSel,
  input wire        writeLocked,
  input wire [7:0]  variantCode,
  // Dividers
  input wire        pllCRefBypassDiv1,
  input wire        pllCRefBypassDiv2,
  input wire [5:0]  pllCRefDivider,
  input wire [6:0]  pllCRefRatio,
  input wire [10:0] pllCFbDivider,
  input wire [10:0] pllAFbDivider
);
  // Bypass /1 wins over /2, and a zero field stands for the top ratio.
  wire [6:0] expCRatio = pllCRefBypassDiv1 ? 7'h01 : pllCRefBypassDiv2 ? 7'h02 :
                         (pllCRefDivider == 6'h00) ? 7'h40 : {1'b0, pllCRefDivider};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  chk_sda_never_high: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  chk_oe_reset_off: assert property ($fell(srst) |-> !sdaOe)
    else $error("data pin pulled right after reset");
  chk_oe_moves_low: assert property ($changed(sdaOe) |->
    !sclIn && !$past(sclIn) && !$past(sclIn, 2))
    else $error("data drive changed too soon after clock fall");
  chk_oe_stands_high: assert property ((sclIn && $past(sclIn)) |-> $stable(sdaOe))
    else $error("data drive changed while clock high");
  chk_general_reset: assert property ($fell(srst) |->
    !nvmProgrammed && targetAddrSel == 2'h0 && !writeLocked)
    else $error("general control not at reset value");
  chk_fb_reset: assert property ($fell(srst) |->
    pllCFbDivider == 11'h1E0 && pllAFbDivider == 11'h258)
    else $error("feedback dividers not at reset value");
  chk_c_ref_ratio: assert property ((!$past(srst) && $past(ce)) |->
    pllCRefRatio == $past(expCRatio))
    else $error("third reference ratio wrong");
  chk_lock_freezes: assert property (writeLocked |=> $stable(variantCode))
    else $error("variant code changed while locked");
endmodule // ccb_config_bank_props

// file: verification/ccb_config_bank_tb.sv
`timescale 1ns/1ns
module ccb_config_bank_tb;
  logic        core_clk, srst, ce;
  wire         sclOut, sdaLowOut, sdaWire, sdaOut, sdaOe, nvmProgrammed;
  wire         pllASpreadEnable, pllCRefSourceSelect, writeLocked;
  wire         pllCRefBypassDiv1, pllCRefBypassDiv2, outDivCSourceSelect;
  wire         pllCRefCurrentSelect, pllARefDoubler, pllARefCurrentSelect;
  wire         pllASecondChannelEnable, pllAExtraPoleEnable;
  wire         pllARefBypassDiv1, pllARefBypassDiv2;
  wire [1:0]   targetAddrSel;
  wire [7:0]   variantCode, pllASpreadRefDivider;
  wire [5:0]   pllCRefDivider, pllARefDivider;
  wire [4:0]   pllCFilter, pllCPumpMult, pllCPumpDivisor, pllAFilter;
  wire [4:0]   pllAPumpDivisor;
  wire [6:0]   pllCRefRatio, pllARefRatio, pllAPumpMult;
  wire [6:0]   outDivARatio, outDivBRatio, outDivERatio;
  wire [10:0]  pllCFbDivider, pllAFbDivider;
  wire [15:0]  pllASpreadFbDivider;
  logic [7:0]  adrW;
  logic [7:0]  wbuf [16];
  logic [7:0]  rbuf [16];
  int          fail_count = 0;
  int          compares = 0;
  localparam logic [7:0] RST_TAB [16] = '{8'h00, 8'h00, 8'h00, 8'h1A, 8'hE0,
    8'h11, 8'h6C, 8'h23, 8'h1A, 8'h58, 8'hB2, 8'h06, 8'h00, 8'h00, 8'h00, 8'h03};
  localparam logic [7:0] FLD_TAB [13] = '{8'h40, 8'hFF, 8'hFF, 8'hC7, 8'hDF,
    8'hC3, 8'h0C, 8'h00, 8'h87, 8'h85, 8'h34, 8'h12, 8'h96};
  // Open-drain data line with a pull-up.
  assign sdaWire = !(sdaLowOut || sdaOe);
  ccb_config_bank i_ccb_config_bank (.core_clk(core_clk), .srst(srst), .ce(ce),
    .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .nvmProgrammed(nvmProgrammed), .targetAddrSel(targetAddrSel),
    .pllASpreadEnable(pllASpreadEnable), .writeLocked(writeLocked),
    .pllCRefSourceSelect(pllCRefSourceSelect), .variantCode(variantCode),
    .pllCRefBypassDiv1(pllCRefBypassDiv1), .pllCRefBypassDiv2(pllCRefBypassDiv2),
    .pllCRefDivider(pllCRefDivider), .pllCRefRatio(pllCRefRatio),
    .pllCFbDivider(pllCFbDivider), .pllCFilter(pllCFilter),
    .outDivCSourceSelect(outDivCSourceSelect), .pllCPumpMult(pllCPumpMult),
    .pllCRefCurrentSelect(pllCRefCurrentSelect), .pllARefDoubler(pllARefDoubler),
    .pllCPumpDivisor(pllCPumpDivisor), .pllARefCurrentSelect(pllARefCurrentSelect),
    .pllASecondChannelEnable(pllASecondChannelEnable), .pllAFilter(pllAFilter),
    .pllAExtraPoleEnable(pllAExtraPoleEnable), .pllARefDivider(pllARefDivider),
    .pllARefBypassDiv1(pllARefBypassDiv1), .pllARefBypassDiv2(pllARefBypassDiv2),
    .pllARefRatio(pllARefRatio), .pllAFbDivider(pllAFbDivider),
    .pllAPumpMult(pllAPumpMult), .pllAPumpDivisor(pllAPumpDivisor),
    .pllASpreadRefDivider(pllASpreadRefDivider), .outDivARatio(outDivARatio),
    .pllASpreadFbDivider(pllASpreadFbDivider), .outDivBRatio(outDivBRatio),
    .outDivERatio(outDivERatio));
  ccb_i2c_host i_ccb_i2c_host (.core_clk(core_clk), .sdaWire(sdaWire),
    .sclOut(sclOut), .sdaLowOut(sdaLowOut));
  task automatic cmp(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Sends m bytes from wbuf although the count byte announces n.
  task automatic wrBlk(input logic [7:0] adr, idx, n, input int m,
                       input logic expAck);
    logic a;
    i_ccb_i2c_host.startCond();
    i_ccb_i2c_host.byteOut(adr, a);
    cmp("address ack", 32'(expAck), 32'(a));
    if (a) begin
      i_ccb_i2c_host.byteOut(idx, a);
      i_ccb_i2c_host.byteOut(n, a);
      for (int k = 0; k < m; k++) begin
        i_ccb_i2c_host.byteOut(wbuf[k], a);
        cmp("data ack", 32'h1, 32'(a));
      end
    end
    i_ccb_i2c_host.stopCond();
  endtask
  task automatic rdBlk(input logic [7:0] idx, input int n);
    logic a;
    logic [7:0] c;
    i_ccb_i2c_host.startCond();
    i_ccb_i2c_host.byteOut(adrW, a);
    i_ccb_i2c_host.byteOut(idx, a);
    i_ccb_i2c_host.startCond();
    i_ccb_i2c_host.byteOut(adrW | 8'h01, a);
    i_ccb_i2c_host.byteIn(1'b0, c);
    cmp("count byte", 32'(8'h10 - idx), 32'(c));
    for (int k = 0; k < n; k++) i_ccb_i2c_host.byteIn(k == n - 1, rbuf[k]);
    i_ccb_i2c_host.stopCond();
  endtask
  task automatic scnReset();
    rdBlk(8'h00, 16);
    for (int k = 0; k < 16; k++) cmp("reset byte", 32'(RST_TAB[k]), 32'(rbuf[k]));
    cmp("ref ratios", 32'hD1A, 32'({pllCRefRatio, pllARefRatio}));
    cmp("fb dividers", 32'hF0258, 32'({pllCFbDivider, pllAFbDivider}));
    cmp("filters", 32'h56, 32'({pllCFilter, pllAFilter}));
    cmp("out ratios", 32'h450A, 32'({outDivARatio, outDivBRatio, outDivERatio}));
    cmp("pumps", 32'h1B8038, 32'({pllCPumpMult, pllCPumpDivisor, pllAPumpMult,
        pllAPumpDivisor}));
    cmp("pll a ctrl", 32'h04, 32'({pllARefDoubler, pllARefCurrentSelect,
        pllASecondChannelEnable, pllAExtraPoleEnable, outDivCSourceSelect}));
  endtask
  task automatic scnFields();
    for (int k = 0; k < 13; k++) wbuf[k] = FLD_TAB[k];
    wrBlk(adrW, 8'h03, 8'h0D, 13, 1'b1);
    cmp("ref ratios", 32'h101, 32'({pllCRefRatio, pllARefRatio}));
    cmp("ref fields", 32'h8187, 32'({pllCRefBypassDiv1, pllCRefBypassDiv2,
        pllCRefDivider, pllARefBypassDiv1, pllARefBypassDiv2, pllARefDivider,
        pllCRefCurrentSelect}));
    cmp("fb dividers", 32'h3FF80C, 32'({pllCFbDivider, pllAFbDivider}));
    cmp("filters", 32'h3E0, 32'({pllCFilter, pllAFilter}));
    cmp("out ratios", 32'h30550, 32'({outDivARatio, outDivBRatio, outDivERatio}));
    cmp("pumps", 32'h21B85B, 32'({pllCPumpMult, pllCPumpDivisor, pllAPumpMult,
        pllAPumpDivisor}));
    cmp("pll a ctrl", 32'h1B, 32'({pllARefDoubler, pllARefCurrentSelect,
        pllASecondChannelEnable, pllAExtraPoleEnable, outDivCSourceSelect}));
    cmp("spread", 32'h851234, 32'({pllASpreadRefDivider, pllASpreadFbDivider}));
    rdBlk(8'h03, 13);
    for (int k = 0; k < 13; k++) cmp("readback", 32'(FLD_TAB[k]), 32'(rbuf[k]));
    wbuf[0] = 8'hAA;
    wbuf[1] = 8'hBB;
    wrBlk(adrW, 8'h0C, 8'h01, 2, 1'b1);
    cmp("overrun", 32'hAA1234, 32'({pllASpreadRefDivider, pllASpreadFbDivider}));
    wbuf[0] = 8'hFF;
    wbuf[1] = 8'h00;
    wrBlk(adrW, 8'h02, 8'h02, 2, 1'b1);
    cmp("zero ref field", 32'h2001, 32'({pllCRefRatio, pllARefRatio}));
    rdBlk(8'h02, 1);
    cmp("reserved byte", 32'h0, 32'(rbuf[0]));
  endtask
  task automatic scnGeneral();
    for (int c = 0; c < 4; c++) begin
      wbuf[0] = {1'b1, 2'(c), 5'h1E};
      wrBlk(adrW, 8'h00, 8'h01, 1, 1'b1);
      wrBlk(8'hD0 + 8'(((c + 3) % 4) * 2), 8'h00, 8'h00, 0, 1'b0);
      adrW = 8'hD0 + 8'(c * 2);
      rdBlk(8'h00, 1);
      cmp("general byte", 32'({1'b1, 2'(c), 5'h14}), 32'(rbuf[0]));
      cmp("general flags", 32'({1'b1, 2'(c), 2'h3}), 32'({nvmProgrammed,
          targetAddrSel, pllASpreadEnable, pllCRefSourceSelect}));
    end
    wbuf[0] = 8'h61;
    wrBlk(adrW, 8'h00, 8'h01, 1, 1'b1);
    wbuf[0] = 8'h5A;
    wrBlk(adrW, 8'h01, 8'h01, 1, 1'b1);
    cmp("locked", 32'h100, 32'({writeLocked, variantCode}));
    wbuf[0] = 8'h00;
    wrBlk(adrW, 8'h00, 8'h01, 1, 1'b1);
    adrW = 8'hD0;
    wbuf[0] = 8'h5A;
    wrBlk(adrW, 8'h01, 8'h01, 1, 1'b1);
    cmp("unlocked", 32'h05A, 32'({writeLocked, variantCode}));
    wbuf[0] = 8'h3C;
    ce = 1'b0;
    wrBlk(adrW, 8'h01, 8'h01, 1, 1'b0);
    ce = 1'b1;
    cmp("frozen", 32'h05A, 32'(variantCode));
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    adrW = 8'hD0;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
    scnReset();
    scnFields();
    scnGeneral();
    close_out();
  end
endmodule // ccb_config_bank_tb
bind ccb_config_bank ccb_config_bank_props i_props (.core_clk(core_clk),
  .srst(srst), .ce(ce), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .nvmProgrammed(nvmProgrammed), .targetAddrSel(targetAddrSel),
  .writeLocked(writeLocked), .variantCode(variantCode),
  .pllCRefBypassDiv1(pllCRefBypassDiv1), .pllCRefBypassDiv2(pllCRefBypassDiv2),
  .pllCRefDivider(pllCRefDivider), .pllCRefRatio(pllCRefRatio),
  .pllCFbDivider(pllCFbDivider), .pllAFbDivider(pllAFbDivider));

// file: verification/ccb_i2c_host.sv
`timescale 1ns/1ns
module ccb_i2c_host (
  // Clock
  input  wire core_clk,
  // Bus lines
  input  wire sdaWire,
  output reg  sclOut,
  output reg  sdaLowOut
);
  localparam int HALF = 5;
  initial begin
    sclOut = 1'b1;
    sdaLowOut = 1'b0;
  end
  task automatic waitHalf();
    repeat (HALF) @(negedge core_clk);
  endtask
  // Data moves one cycle after the clock falls, so it never races the fall.
  task automatic clockBit(input logic drv, output logic seen);
    @(negedge core_clk);
    sdaLowOut = !drv;
    waitHalf();
    sclOut = 1'b1;
    waitHalf();
    seen = sdaWire;
    sclOut = 1'b0;
  endtask
  task automatic startCond();
    @(negedge core_clk);
    sdaLowOut = 1'b0;
    waitHalf();
    sclOut = 1'b1;
    waitHalf();
    sdaLowOut = 1'b1;
    waitHalf();
    sclOut = 1'b0;
  endtask
  task automatic stopCond();
    @(negedge core_clk);
    sdaLowOut = 1'b1;
    waitHalf();
    sclOut = 1'b1;
    waitHalf();
    sdaLowOut = 1'b0;
    waitHalf();
  endtask
  task automatic byteOut(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clockBit(b[i], s);
    clockBit(1'b1, s);
    ack = !s;
  endtask
  // The last byte of a read is answered with a not-acknowledge.
  task automatic byteIn(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clockBit(1'b1, s);
      b[i] = s;
    end
    clockBit(last, s);
  endtask
endmodule // ccb_i2c_host
